// [verilog/adc_regs_pkg.sv]
package adc_regs_pkg;

   // ----------------------------------------------------------------
   // register indices (byte address is four times the index)
   // ----------------------------------------------------------------
   localparam logic [7:0]  IDX_HEALTH     = 8'h00;
   localparam logic [7:0]  IDX_CORE       = 8'h01;
   localparam logic [7:0]  IDX_FORMAT     = 8'h02;
   localparam logic [7:0]  IDX_SEQ        = 8'h10;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int unsigned HLT_FIXED_BIT  = 7;
   localparam int unsigned HLT_SEQ_BIT    = 6;
   localparam int unsigned HLT_FUSE_BIT   = 2;
   localparam int unsigned HLT_CRC_BIT    = 1;
   localparam int unsigned HLT_BOR_BIT    = 0;
   localparam int unsigned CORE_REF_BIT   = 7;
   localparam int unsigned CORE_CRC_BIT   = 6;
   localparam int unsigned CORE_RANGE_BIT = 3;
   localparam int unsigned CORE_FORCE_BIT = 2;
   localparam int unsigned CORE_CAL_BIT   = 1;
   localparam int unsigned CORE_RST_BIT   = 0;
   localparam int unsigned FMT_PAT_BIT    = 7;
   localparam int unsigned FMT_APP_LO     = 4;
   localparam int unsigned FMT_MODE_LO    = 0;
   localparam int unsigned SEQ_GO_BIT     = 0;

   // ----------------------------------------------------------------
   // reset values and writable masks
   // ----------------------------------------------------------------
   localparam logic [7:0]  HEALTH_RESET   = 8'h81;
   localparam logic [7:0]  CORE_RESET     = 8'h00;
   localparam logic [7:0]  FORMAT_RESET   = 8'h00;
   localparam logic [7:0]  CORE_STORE     = 8'hCE;
   localparam logic [7:0]  FORMAT_STORE   = 8'hB3;

   // ----------------------------------------------------------------
   // output data format, fuse evaluation count and bus transfer type
   // ----------------------------------------------------------------
   localparam logic [15:0] TEST_PATTERN   = 16'hA5A5;
   localparam logic [1:0]  APP_NONE       = 2'h0;
   localparam logic [1:0]  APP_CHAN       = 2'h1;
   localparam logic [1:0]  APP_STAT       = 2'h2;
   localparam logic [1:0]  FUSE_EVAL_CNT  = 2'h3;
   localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;

   // configuration carried to the link domain
   typedef struct packed {
      logic       crc_on;
      logic       pattern_on;
      logic [1:0] append_sel;
      logic [1:0] serial_mode;
      logic       seq_go;
   } link_cfg_t;

   // captured bus address phase
   typedef struct packed {
      logic [7:0] idx;
      logic       write;
      logic       valid;
   } ahb_req_t;

endpackage

// [verilog/adc_status_config_regs.sv]
// The implementer's own choice: the AHB-Lite slave port.
`timescale 1ns/100ps

// Notes on behaviour
// RULE1: status bit 6 shows 1 while the channel sequencer runs and 0 when it is stopped.
// RULE2: the power-up configuration crc failure flag is only evaluated after reset or soft reset.
// RULE3: an input crc failure sets a flag that software clears by writing 1 to it.
// RULE4: while the input crc flag is set only writes to indices 0x00 and 0x01 take effect.
// RULE5: the brown-out flag is set by a brown-out or power cycle and stays until written with 1.
// RULE6: the reference enable bit powers the internal reference down at 0, up at 1, reset 0.
// RULE7: the crc enable bit turns on crc append on output and crc check on input.
// RULE8: the range bit selects one times reference at 0 and twice reference at 1.
// RULE9: the force-analog bit makes every channel an analog input regardless of other setup.
// RULE10: writing 1 to the calibrate bit starts offset calibration, cleared when it finishes.
// RULE11: writing 1 to the reset bit restores all defaults and sets the brown-out flag.
// RULE12: with the test pattern bit set the output word is the constant 0xA5A5.
// RULE13: the append field selects plain data, a 4-bit channel id, 4-bit status, or reserved.
// RULE14: the serial mode field sets clock polarity and phase for the serial link.
// RULE15: after any reset status reads 0x81 and the two configuration registers read zero; the code reads 0x85 when the configuration crc check fails.
// RULE16: writes to read-only and reserved fields are ignored and those fields keep reset value.
// RULE17: the sequencer runs and reads active while the sequencer start bit is 1.
module adc_status_config_regs
   import adc_regs_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        arst_n,
   input  wire logic        ce,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        brownout_in,
   input  wire logic        fuse_crc_bad_in,
   input  wire logic        cal_done_in,
   output logic             ref_enable,
   output logic             range_2x,
   output logic             force_all_analog,
   output logic             cal_busy,
   input  wire logic        link_clk,
   input  wire logic        link_crc_bad,
   input  wire logic        conv_valid,
   input  wire logic [15:0] conv_data,
   input  wire logic [3:0]  conv_chan,
   input  wire logic [3:0]  conv_flags,
   output logic             link_word_valid,
   output logic      [15:0] link_word,
   output logic      [3:0]  link_tag,
   output logic             link_tag_on,
   output logic             link_crc_append,
   output logic             link_cpol,
   output logic             link_cpha,
   output logic             seq_running
);

   // ----------------------------------------------------------------
   // register state, bus side
   // ----------------------------------------------------------------
   logic      [7:0] core_r;
   logic      [7:0] format_r;
   logic            seq_go_r;
   logic            crc_flag_r;
   logic            bor_flag_r;
   logic            fuse_flag_r;
   logic      [1:0] fuse_cnt_r;
   logic            soft_rst_r;
   ahb_req_t        req_r;
   link_cfg_t       cfg_r;
   logic      [7:0] health_view;
   logic            wr_go;
   logic            wr_blocked;
   logic      [7:0] wdat;

   // ----------------------------------------------------------------
   // pin synchronisers and crossings into the bus domain
   // ----------------------------------------------------------------
   logic [3:0] pin_s1_r;
   logic [3:0] pin_s2_r;
   logic       cal_done_d_r;
   logic       crc_tgl_s1_r;
   logic       crc_tgl_s2_r;
   logic       crc_tgl_s3_r;
   logic       crc_event;
   logic       cal_done_rise;
   logic       link_crc_tgl_r;

   // word address decoding shared by reads and writes
   function automatic logic [7:0] word_index(input logic [31:0] a);
      return a[9:2];
   endfunction

   // two flops on every asynchronous pin and on the running level
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pin_s1_r <= 4'h0;
         pin_s2_r <= 4'h0;
      end else if (ce) begin
         pin_s1_r <= {seq_running, cal_done_in, fuse_crc_bad_in, brownout_in};
         pin_s2_r <= pin_s1_r;
      end
   end

   // toggle crossing for crc events, edge taken behind the second flop
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         crc_tgl_s1_r <= 1'b0;
         crc_tgl_s2_r <= 1'b0;
         crc_tgl_s3_r <= 1'b0;
         cal_done_d_r <= 1'b0;
      end else if (ce) begin
         crc_tgl_s1_r <= link_crc_tgl_r;
         crc_tgl_s2_r <= crc_tgl_s1_r;
         crc_tgl_s3_r <= crc_tgl_s2_r;
         cal_done_d_r <= pin_s2_r[2];
      end
   end

   assign crc_event     = crc_tgl_s2_r ^ crc_tgl_s3_r;
   assign cal_done_rise = pin_s2_r[2] & ~cal_done_d_r;

   // ----------------------------------------------------------------
   // ahb-lite slave
   // ----------------------------------------------------------------
   // address phase capture; reads take one wait state
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         req_r     <= '0;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else if (ce) begin
         hresp     <= 1'b0; // always okay
         if (hready) begin
            req_r.valid <= hsel & (htrans == HTRANS_NONSEQ);
            req_r.write <= hwrite;
            req_r.idx   <= word_index(haddr);
            hreadyout   <= ~(hsel & (htrans == HTRANS_NONSEQ) & ~hwrite);
         end else begin
            req_r.valid <= req_r.valid & req_r.write;
            hreadyout   <= 1'b1;
         end
      end
   end

   assign wdat  = hwdata[7:0];
   assign wr_go = req_r.valid & req_r.write & hreadyout;
   // writes beyond the first two indices are dropped while crc flag stands
   assign wr_blocked = crc_flag_r & (req_r.idx != IDX_HEALTH) & (req_r.idx != IDX_CORE); // RULE4

   // status view: fixed one, sequencer, reserved zero, flags
   always_comb begin
      health_view               = 8'h00; // RULE16
      health_view[HLT_FIXED_BIT] = HEALTH_RESET[HLT_FIXED_BIT]; // RULE15
      health_view[HLT_SEQ_BIT]  = pin_s2_r[3]; // RULE1
      health_view[HLT_FUSE_BIT] = fuse_flag_r;
      health_view[HLT_CRC_BIT]  = crc_flag_r;
      health_view[HLT_BOR_BIT]  = bor_flag_r;
   end

   // read data registered in the wait state; unmapped reads give zero
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         hrdata <= 32'h0000_0000;
      end else if (ce && req_r.valid && !req_r.write && !hreadyout) begin
         unique case (req_r.idx)
            IDX_HEALTH: hrdata <= {24'h00_0000, health_view};
            IDX_CORE:   hrdata <= {24'h00_0000, core_r & ~8'h01}; // RULE16
            IDX_FORMAT: hrdata <= {24'h00_0000, format_r};
            IDX_SEQ:    hrdata <= {31'h0000_0000, seq_go_r};
            default:    hrdata <= 32'h0000_0000;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // configuration registers
   // ----------------------------------------------------------------
   // core control: stored bits, calibrate auto-clear, reset strobe
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         core_r <= CORE_RESET; // RULE15
      end else if (ce) begin
         if (soft_rst_r) begin
            core_r <= CORE_RESET; // RULE11
         end else begin
            // a new start written in the same cycle wins over the finish
            if (cal_done_rise && core_r[CORE_CAL_BIT]) begin
               core_r[CORE_CAL_BIT] <= 1'b0; // RULE10
            end
            if (wr_go && !wr_blocked && req_r.idx == IDX_CORE) begin
               core_r <= (wdat & CORE_STORE) | {7'h00, wdat[CORE_RST_BIT]}; // RULE16
            end else begin
               core_r[CORE_RST_BIT] <= 1'b0;
            end
         end
      end
   end

   // soft reset pulse follows a write of the reset bit
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         soft_rst_r <= 1'b0;
      end else if (ce) begin
         soft_rst_r <= core_r[CORE_RST_BIT] & ~soft_rst_r; // RULE11
      end
   end

   // data format and sequencer start registers
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         format_r <= FORMAT_RESET; // RULE15
         seq_go_r <= 1'b0;
      end else if (ce) begin
         if (soft_rst_r) begin
            format_r <= FORMAT_RESET; // RULE11
            seq_go_r <= 1'b0;
         end else if (wr_go && !wr_blocked) begin // RULE4
            if (req_r.idx == IDX_FORMAT) begin
               format_r <= wdat & FORMAT_STORE; // RULE16
            end
            if (req_r.idx == IDX_SEQ) begin
               seq_go_r <= wdat[SEQ_GO_BIT]; // RULE17
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // status flags
   // ----------------------------------------------------------------
   // input crc flag: event set wins over write-one clear
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         crc_flag_r <= 1'b0;
      end else if (ce) begin
         if (crc_event) begin
            crc_flag_r <= 1'b1; // RULE3
         end else if (soft_rst_r) begin
            crc_flag_r <= 1'b0;
         end else if (wr_go && req_r.idx == IDX_HEALTH && wdat[HLT_CRC_BIT]) begin
            crc_flag_r <= 1'b0; // RULE3
         end
      end
   end

   // brown-out flag: pin or soft reset sets, write one clears
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         bor_flag_r <= HEALTH_RESET[HLT_BOR_BIT]; // RULE5
      end else if (ce) begin
         if (pin_s2_r[0] || soft_rst_r) begin
            bor_flag_r <= 1'b1; // RULE5
         end else if (wr_go && req_r.idx == IDX_HEALTH && wdat[HLT_BOR_BIT]) begin
            bor_flag_r <= 1'b0; // RULE5
         end
      end
   end

   // configuration crc result caught once the pin has passed its flops
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         fuse_cnt_r  <= FUSE_EVAL_CNT;
         fuse_flag_r <= 1'b0;
      end else if (ce) begin
         if (soft_rst_r) begin
            fuse_cnt_r  <= FUSE_EVAL_CNT; // RULE2
            fuse_flag_r <= 1'b0;
         end else if (fuse_cnt_r != 2'h0) begin
            fuse_cnt_r <= fuse_cnt_r - 2'h1;
            if (fuse_cnt_r == 2'h1) begin
               fuse_flag_r <= pin_s2_r[1]; // RULE2
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // analog controls and configuration for the link
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ref_enable       <= 1'b0;
         range_2x         <= 1'b0;
         force_all_analog <= 1'b0;
         cal_busy         <= 1'b0;
         cfg_r            <= '0;
      end else if (ce) begin
         ref_enable        <= core_r[CORE_REF_BIT]; // RULE6
         range_2x          <= core_r[CORE_RANGE_BIT]; // RULE8
         force_all_analog  <= core_r[CORE_FORCE_BIT]; // RULE9
         cal_busy          <= core_r[CORE_CAL_BIT]; // RULE10
         cfg_r.crc_on      <= core_r[CORE_CRC_BIT]; // RULE7
         cfg_r.pattern_on  <= format_r[FMT_PAT_BIT];
         cfg_r.append_sel  <= format_r[FMT_APP_LO +: 2];
         cfg_r.serial_mode <= format_r[FMT_MODE_LO +: 2];
         cfg_r.seq_go      <= seq_go_r;
      end
   end

   // ----------------------------------------------------------------
   // link clock domain
   // ----------------------------------------------------------------
   logic      link_rst_s1_r;
   logic      link_rst_n_r;
   link_cfg_t lcfg_s1_r;
   link_cfg_t lcfg_s2_r;
   link_cfg_t lcfg_s3_r;
   link_cfg_t lcfg_r;

   // reset release synchronised to the link clock
   always_ff @(posedge link_clk or negedge arst_n) begin
      if (!arst_n) begin
         link_rst_s1_r <= 1'b0;
         link_rst_n_r  <= 1'b0;
      end else begin
         link_rst_s1_r <= 1'b1;
         link_rst_n_r  <= link_rst_s1_r;
      end
   end

   // configuration through three flops, taken only when two samples agree
   // so that a multi-bit field never arrives half old and half new
   always_ff @(posedge link_clk or negedge link_rst_n_r) begin
      if (!link_rst_n_r) begin
         lcfg_s1_r <= '0;
         lcfg_s2_r <= '0;
         lcfg_s3_r <= '0;
         lcfg_r    <= '0;
      end else begin
         lcfg_s1_r <= cfg_r;
         lcfg_s2_r <= lcfg_s1_r;
         lcfg_s3_r <= lcfg_s2_r;
         if (lcfg_s2_r == lcfg_s3_r) begin
            lcfg_r <= lcfg_s3_r;
         end
      end
   end

   // crc failures counted only while checking is enabled
   always_ff @(posedge link_clk or negedge link_rst_n_r) begin
      if (!link_rst_n_r) begin
         link_crc_tgl_r <= 1'b0;
      end else if (link_crc_bad && lcfg_r.crc_on) begin
         link_crc_tgl_r <= ~link_crc_tgl_r; // RULE7
      end
   end

   // sequencer run state and serial mode outputs
   always_ff @(posedge link_clk or negedge link_rst_n_r) begin
      if (!link_rst_n_r) begin
         seq_running     <= 1'b0;
         link_crc_append <= 1'b0;
         link_cpol       <= 1'b0;
         link_cpha       <= 1'b0;
      end else begin
         seq_running     <= lcfg_r.seq_go; // RULE17
         link_crc_append <= lcfg_r.crc_on; // RULE7
         link_cpol       <= lcfg_r.serial_mode[1]; // RULE14
         link_cpha       <= lcfg_r.serial_mode[0]; // RULE14
      end
   end

   // output word formatting per conversion
   always_ff @(posedge link_clk or negedge link_rst_n_r) begin
      if (!link_rst_n_r) begin
         link_word_valid <= 1'b0;
         link_word       <= 16'h0000;
         link_tag        <= 4'h0;
         link_tag_on     <= 1'b0;
      end else begin
         link_word_valid <= conv_valid;
         if (conv_valid) begin
            link_word <= lcfg_r.pattern_on ? TEST_PATTERN : conv_data; // RULE12
            unique case (lcfg_r.append_sel)
               APP_CHAN: begin
                  link_tag    <= conv_chan; // RULE13
                  link_tag_on <= 1'b1;
               end
               APP_STAT: begin
                  link_tag    <= conv_flags; // RULE13
                  link_tag_on <= 1'b1;
               end
               default: begin
                  link_tag    <= 4'h0; // RULE13
                  link_tag_on <= 1'b0;
               end
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   a_blocked_fmt_write: assert property (@(posedge clk) disable iff (!arst_n) // RULE4
      ce && wr_go && crc_flag_r && req_r.idx == IDX_FORMAT && !soft_rst_r
      |=> $stable(format_r))
      else $error("format written while crc flag set");

   a_crc_set_wins: assert property (@(posedge clk) disable iff (!arst_n) // RULE3
      ce && crc_event |=> crc_flag_r)
      else $error("crc event lost");

   a_crc_w1c: assert property (@(posedge clk) disable iff (!arst_n) // RULE3
      ce && !crc_event && wr_go && req_r.idx == IDX_HEALTH && wdat[HLT_CRC_BIT]
      |=> !crc_flag_r)
      else $error("crc flag not cleared");

   a_bor_after_soft: assert property (@(posedge clk) disable iff (!arst_n) // RULE11
      ce && soft_rst_r |=> bor_flag_r && core_r == CORE_RESET && format_r == FORMAT_RESET)
      else $error("soft reset incomplete");

   a_rst_bit_to_soft: assert property (@(posedge clk) disable iff (!arst_n) // RULE11
      ce && core_r[CORE_RST_BIT] && !soft_rst_r |=> soft_rst_r)
      else $error("reset bit did not start soft reset");

   a_cal_clears: assert property (@(posedge clk) disable iff (!arst_n) // RULE10
      ce && cal_done_rise && core_r[CORE_CAL_BIT] && !soft_rst_r && !wr_go
      |=> !core_r[CORE_CAL_BIT])
      else $error("calibrate bit not cleared");

   a_ref_follows: assert property (@(posedge clk) disable iff (!arst_n) // RULE6
      ce ##1 ce |-> ref_enable == $past(core_r[CORE_REF_BIT]))
      else $error("reference enable mismatch");

   a_health_fixed: assert property (@(posedge clk) disable iff (!arst_n) // RULE16
      health_view[HLT_FIXED_BIT] && health_view[5:3] == 3'h0)
      else $error("reserved status bits wrong");

   a_pattern_word: assert property (@(posedge link_clk) disable iff (!link_rst_n_r) // RULE12
      conv_valid && lcfg_r.pattern_on |=> link_word == TEST_PATTERN)
      else $error("test pattern not output");

   a_seq_track: assert property (@(posedge link_clk) disable iff (!link_rst_n_r) // RULE17
      $rose(lcfg_r.seq_go) |=> seq_running)
      else $error("sequencer not running");

   c_soft_reset: cover property (@(posedge clk) disable iff (!arst_n) soft_rst_r);
   c_crc_blocked: cover property (@(posedge clk) disable iff (!arst_n) wr_go && wr_blocked);
   c_cal_done: cover property (@(posedge clk) disable iff (!arst_n)
      cal_done_rise && core_r[CORE_CAL_BIT]);
   c_tag_chan: cover property (@(posedge link_clk) disable iff (!link_rst_n_r)
      conv_valid && lcfg_r.append_sel == APP_CHAN);

endmodule // adc_status_config_regs

// [tb/host_link_model.sv]
`timescale 1ns/100ps

// host side of the link: sends conversion words and crc faults on command
module host_link_model (
   input  wire logic        link_clk,
   input  wire logic        link_cpol,
   input  wire logic        link_cpha,
   output logic             conv_valid,
   output logic      [15:0] conv_data,
   output logic      [3:0]  conv_chan,
   output logic      [3:0]  conv_flags,
   output logic             link_crc_bad
);
   logic [1:0] host_mode_r;

   // quiet lines at start
   initial begin
      conv_valid = 1'b0;
      conv_data = 16'h0000;
      conv_chan = 4'h0;
      conv_flags = 4'h0;
      link_crc_bad = 1'b0;
   end

   // host follows the clock mode the device announces
   always @(posedge link_clk) begin
      host_mode_r <= {link_cpol, link_cpha};
   end

   // one word for one link cycle, then the lines show the inverse
   task automatic send(input logic [15:0] d, input logic [3:0] c, input logic [3:0] f);
      @(posedge link_clk);
      conv_valid <= 1'b1;
      conv_data <= d;
      conv_chan <= c;
      conv_flags <= f;
      @(posedge link_clk);
      conv_valid <= 1'b0;
      conv_data <= ~d;
      conv_chan <= ~c;
      conv_flags <= ~f;
   endtask

   // one cycle of failed crc on incoming data
   task automatic crc_fail();
      @(posedge link_clk);
      link_crc_bad <= 1'b1;
      @(posedge link_clk);
      link_crc_bad <= 1'b0;
   endtask
endmodule // host_link_model

// [tb/tb.sv]
`timescale 1ns/100ps

module tb;
   import adc_regs_pkg::*;
   logic        clk = 1'b0;
   logic        link_clk = 1'b0;
   logic        arst_n = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic        brownout_in = 1'b0;
   logic        fuse_crc_bad_in = 1'b0;
   logic        cal_done_in = 1'b0;
   logic [31:0] hrdata;
   logic        hreadyout, ref_enable, range_2x, force_all_analog, cal_busy, seq_running;
   logic        conv_valid, link_crc_bad, link_word_valid, link_tag_on, link_crc_append;
   logic        link_cpol, link_cpha;
   logic [15:0] conv_data, link_word;
   logic [3:0]  conv_chan, conv_flags, link_tag;
   int          failures = 0;
   int          compares = 0;
   // rows of {index, write data, read back}
   logic [23:0] rows [0:6] = '{24'h01FECE, 24'h010000, 24'h02FFB3, 24'h020000,
                               24'h000081, 24'h000180, 24'h03FF00};
   logic [7:0]  fmts [0:3] = '{8'h80, 8'h11, 8'h23, 8'h32};

   always #4 clk = ~clk;
   always #62.5 link_clk = ~link_clk;

   adc_status_config_regs dut (.clk(clk), .arst_n(arst_n), .ce(1'b1), .hsel(1'b1),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(),
      .brownout_in(brownout_in), .fuse_crc_bad_in(fuse_crc_bad_in), .cal_done_in(cal_done_in),
      .ref_enable(ref_enable), .range_2x(range_2x), .force_all_analog(force_all_analog),
      .cal_busy(cal_busy), .link_clk(link_clk), .link_crc_bad(link_crc_bad),
      .conv_valid(conv_valid), .conv_data(conv_data), .conv_chan(conv_chan),
      .conv_flags(conv_flags), .link_word_valid(link_word_valid), .link_word(link_word),
      .link_tag(link_tag), .link_tag_on(link_tag_on), .link_crc_append(link_crc_append),
      .link_cpol(link_cpol), .link_cpha(link_cpha), .seq_running(seq_running));

   host_link_model host (.link_clk(link_clk), .link_cpol(link_cpol), .link_cpha(link_cpha),
      .conv_valid(conv_valid), .conv_data(conv_data), .conv_chan(conv_chan),
      .conv_flags(conv_flags), .link_crc_bad(link_crc_bad));

   // ----------------------------------------------------------------
   // checking and bus tasks
   // ----------------------------------------------------------------
   task automatic cmp(input string name, input logic [15:0] exp, input logic [15:0] got);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic wrap_up();
      if (failures == 0 && compares > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // waits for hready high, sampled at the falling edge before each rising edge, taking read data there
   task automatic rdy(output logic [7:0] q);
      logic r;
      int   n = 0;
      do begin
         @(negedge clk);
         r = hreadyout;
         q = hrdata[7:0];
         @(posedge clk);
         n++;
      end while (r !== 1'b1 && n < 20);
      if (r !== 1'b1) begin
         failures++;
         wrap_up();
      end
   endtask

   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] q);
      @(posedge clk);
      htrans <= HTRANS_NONSEQ;
      haddr <= {22'h0, a, 2'h0};
      hwrite <= w;
      rdy(q);
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      rdy(q);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] q;
      bus(1'b1, a, d, q);
   endtask

   // polls a register, since status crosses clock domains
   task automatic reg_is(input logic [7:0] a, input logic [7:0] e, input string name);
      logic [7:0] q;
      int         n = 0;
      do begin
         bus(1'b0, a, 8'h00, q);
         n++;
      end while (q !== e && n < 40);
      cmp(name, {8'h00, e}, {8'h00, q});
   endtask

   // one word through the link under format f
   task automatic link_is(input logic [7:0] f);
      logic on;
      on = (f[5:4] == APP_CHAN) || (f[5:4] == APP_STAT);
      host.send(16'h1234, 4'h5, 4'hA);
      @(negedge link_clk);
      cmp("link_word", f[7] ? 16'hA5A5 : 16'h1234, link_word);
      cmp("tag_on", {15'h0, on}, {15'h0, link_tag_on});
      if (on) begin
         cmp("tag", (f[5:4] == APP_CHAN) ? 16'h5 : 16'hA, {12'h0, link_tag});
      end
      cmp("mode", {14'h0, f[1:0]}, {14'h0, link_cpol, link_cpha});
      cmp("host_mode", {14'h0, f[1:0]}, {14'h0, host.host_mode_r});
      cmp("word_valid", 16'h1, {15'h0, link_word_valid});
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (12) @(posedge clk);
      arst_n <= 1'b1;
      repeat (4) @(posedge clk);
      reg_is(IDX_HEALTH, 8'h81, "health_reset");
      reg_is(IDX_CORE, 8'h00, "core_reset");
      reg_is(IDX_FORMAT, 8'h00, "format_reset");
      for (int i = 0; i < 7; i++) begin
         wr(rows[i][23:16], rows[i][15:8]);
         reg_is(rows[i][23:16], rows[i][7:0], "readback");
      end
      wr(IDX_CORE, 8'h40);
      repeat (8) @(posedge link_clk);
      host.crc_fail();
      reg_is(IDX_HEALTH, 8'h82, "crc_flag");
      wr(IDX_FORMAT, 8'h80);
      reg_is(IDX_FORMAT, 8'h00, "blocked");
      wr(IDX_CORE, 8'hCC);
      reg_is(IDX_CORE, 8'hCC, "core_open");
      cmp("ref", 16'h1, {15'h0, ref_enable});
      cmp("range", 16'h1, {15'h0, range_2x});
      cmp("force", 16'h1, {15'h0, force_all_analog});
      wr(IDX_HEALTH, 8'h02);
      reg_is(IDX_HEALTH, 8'h80, "crc_clear");
      cmp("crc_append", 16'h1, {15'h0, link_crc_append});
      foreach (fmts[i]) begin
         wr(IDX_FORMAT, fmts[i]);
         repeat (8) @(posedge link_clk);
         link_is(fmts[i]);
      end
      wr(IDX_SEQ, 8'h01);
      reg_is(IDX_HEALTH, 8'hC0, "seq_on");
      cmp("seq_running", 16'h1, {15'h0, seq_running});
      wr(IDX_SEQ, 8'h00);
      reg_is(IDX_HEALTH, 8'h80, "seq_off");
      wr(IDX_CORE, 8'h02);
      reg_is(IDX_CORE, 8'h02, "cal_run");
      cmp("cal_busy", 16'h1, {15'h0, cal_busy});
      cal_done_in <= 1'b1;
      repeat (4) @(posedge clk);
      cal_done_in <= 1'b0;
      reg_is(IDX_CORE, 8'h00, "cal_done");
      brownout_in <= 1'b1;
      repeat (4) @(posedge clk);
      brownout_in <= 1'b0;
      fuse_crc_bad_in <= 1'b1;
      reg_is(IDX_HEALTH, 8'h81, "brownout");
      wr(IDX_HEALTH, 8'h01);
      reg_is(IDX_HEALTH, 8'h80, "fuse_held");
      wr(IDX_CORE, 8'h01);
      reg_is(IDX_HEALTH, 8'h85, "soft_reset");
      reg_is(IDX_FORMAT, 8'h00, "fmt_default");
      wrap_up();
   end
endmodule // tb
